//--- verilog/vdc_defines.svh
`ifndef VDC_DEFINES_SVH
`define VDC_DEFINES_SVH
// Widths and depths of the memory and the serial buffer
`define VDC_ADDR_W     9
`define VDC_DATA_W     16
`define VDC_MEM_WORDS  262144
`define VDC_SAM_WORDS  512
`define VDC_COL_LAST   9'h1ff
`define VDC_HALF_BIT   8
`define VDC_HALF_LAST  8'hff
`define VDC_BLK_COLS   8
`define VDC_BLK_LSB    3
`define VDC_ZERO_WORD  16'h0000
`define VDC_ZERO_ADDR  9'h000
`define VDC_ZERO_HALF  8'h00
`define VDC_ONES_WORD  16'hffff
`define VDC_SYNC_W     49
`endif

//--- verilog/vdc_pkg.sv
package vdc_pkg;
	// Cycle type decided at the row strobe fall
	typedef struct packed {
		logic refresh;   // column strobe low: refresh only
		logic transfer;  // row <-> serial buffer transfer
		logic masked;    // a byte write enable was low
		logic func_row;  // function select at row strobe fall
	} vdc_mode_s;

	typedef enum logic [2:0] {
		VDC_IDLE = 3'b001,
		VDC_ROW  = 3'b010,
		VDC_WALK = 3'b100
	} vdc_state_e;
endpackage

//--- verilog/vdc_sync2.sv
`timescale 1ns/1ps
// Two-flop synchroniser for a group of pin inputs
module vdc_sync2 #(
	parameter int W = 1
) (
	input  wire logic         i_clk_sys,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] meta;

	// First stage is read only by the second stage
	always_ff @(posedge i_clk_sys) begin
		meta   <= i_async;
		o_sync <= meta;
	end
endmodule

//--- verilog/vdc_dram_control.sv
`timescale 1ns/1ps
// Operation
// - Row then column address share nine pins to pick one word.
// - Row bits latch on row strobe fall, column bits on column strobe fall.
// - Row strobe high means standby; a cycle starts at its fall.
// - Mode comes from strobe, transfer, write enables, function at row fall.
// - Function select at column fall picks read/write or block write.
// - Read data is driven only while the column strobe is low.
// - Transfer pin high at row fall makes it the output enable.
// - Transfer pin low at row fall makes a row/buffer transfer.
// - Both write enables high: unmasked; either low: per-bit masked writes.
// - Transfer with enables high reads row to buffer, else buffer to row.
// - Data pins at row fall form the mask; low bits keep contents.
// - Serial port moves one word per serial clock rising edge.
// - Serial enable gates outputs, or enables capture in input mode.
// - Serial enable high blocks access but the pointer still advances.
// - Function select sampled at both strobe falls selects special cycles.
// - Half indicator low for words 0-255, high for 256-511.
// - Half indicator driven only while serial enable is low.
// - Serial direction follows the latest transfer cycle type.
// - Split transfers honour stop addresses, then switch buffer halves.
// - Latched write mask holds for the whole row cycle and page accesses.
// - A sixteen-bit color value feeds flash and block writes.
// - Block write makes three low column bits; data pins pick which of eight columns get color.
// - Flash write stores color into the whole row under the mask.
`include "vdc_defines.svh"
module vdc_dram_control (
	input  wire logic                     i_clk_sys,
	input  wire logic                     i_rstn,
	input  wire logic                     i_ras_n,
	input  wire logic                     i_cas_n,
	input  wire logic                     i_transfer_output_enable_n,
	input  wire logic                     i_write_enable_low_byte_n,
	input  wire logic                     i_write_enable_high_byte_n,
	input  wire logic                     i_function_select_in,
	input  wire logic [`VDC_ADDR_W-1:0]   i_mux_address_pins,
	input  wire logic [`VDC_DATA_W-1:0]   i_dq,
	output logic      [`VDC_DATA_W-1:0]   o_dq,
	output logic                          o_dq_oe,
	input  wire logic                     i_serial_clock,
	input  wire logic                     i_serial_enable_n,
	input  wire logic [`VDC_DATA_W-1:0]   i_serial_data_pins,
	output logic      [`VDC_DATA_W-1:0]   o_serial_data_pins,
	output logic                          o_serial_data_oe,
	output logic                          o_split_half_indicator,
	output logic                          o_split_half_indicator_oe,
	output vdc_pkg::vdc_mode_s            o_mode
);
	import vdc_pkg::*;

	//------------------------------------------------------------
	// Pin synchronisers and edge detection
	//------------------------------------------------------------
	logic [`VDC_SYNC_W-1:0] pins_s;
	logic ras_s, cas_s, trg_s, wel_s, weu_s, dsf_s, sc_s, se_s;
	logic [`VDC_ADDR_W-1:0] adr_s;
	logic [`VDC_DATA_W-1:0] dq_s, sdi_s;
	logic ras_q, cas_q, sc_q;
	logic ras_fall, cas_fall, sc_rise;

	vdc_sync2 #(.W(`VDC_SYNC_W)) u_sync (
		.i_clk_sys (i_clk_sys),
		.i_async   ({i_ras_n, i_cas_n, i_transfer_output_enable_n,
		             i_write_enable_low_byte_n, i_write_enable_high_byte_n,
		             i_function_select_in, i_serial_clock, i_serial_enable_n,
		             i_mux_address_pins, i_dq, i_serial_data_pins}),
		.o_sync    (pins_s)
	);

	assign {ras_s, cas_s, trg_s, wel_s, weu_s, dsf_s, sc_s, se_s,
	        adr_s, dq_s, sdi_s} = pins_s;

	// Previous levels, for edge detection on the synchronised strobes
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			ras_q <= 1'b1;
			cas_q <= 1'b1;
			sc_q  <= 1'b0;
		end else begin
			ras_q <= ras_s;
			cas_q <= cas_s;
			sc_q  <= sc_s;
		end
	end

	assign ras_fall = ras_q && !ras_s;
	assign cas_fall = cas_q && !cas_s;
	assign sc_rise  = !sc_q && sc_s;

	//------------------------------------------------------------
	// Storage
	//------------------------------------------------------------
	logic [`VDC_DATA_W-1:0] mem [`VDC_MEM_WORDS];
	logic [`VDC_DATA_W-1:0] serial_access_buffer [`VDC_SAM_WORDS];

	vdc_state_e             state;
	vdc_mode_s              mode;
	logic [`VDC_ADDR_W-1:0] row, walk_col, ptr, tap;
	logic [`VDC_DATA_W-1:0] wmask, color;
	logic                   split, out_mode, walk_split;
	logic [7:0]             stop_lo, stop_hi;
	logic [`VDC_ADDR_W-1:0] col_a;
	logic                   ram_wr_now, cas_rw;

	//------------------------------------------------------------
	// Row cycle sequencer
	//------------------------------------------------------------
	// A row strobe fall during a walk is ignored: the walk owns the row
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			state    <= VDC_IDLE;
			mode     <= '0;
			row      <= `VDC_ZERO_ADDR;
			wmask    <= `VDC_ONES_WORD;
			walk_col <= `VDC_ZERO_ADDR;
		end else begin
			case (state)
			VDC_IDLE: begin
				if (ras_fall) begin
					row           <= adr_s;
					mode.refresh  <= !cas_s;
					mode.transfer <= !trg_s;
					mode.masked   <= !(wel_s && weu_s);
					mode.func_row <= dsf_s;
					// Mask held until the next row strobe fall
					wmask <= (wel_s && weu_s) ? `VDC_ONES_WORD : dq_s;
					state <= VDC_ROW;
				end
			end
			VDC_ROW: begin
				if (ras_s) begin
					state <= VDC_IDLE;
				end else if (cas_fall && !mode.refresh &&
				             (mode.transfer || (mode.func_row && mode.masked))) begin
					// Transfers and flash writes sweep the row
					walk_col <= `VDC_ZERO_ADDR;
					state    <= VDC_WALK;
				end
			end
			VDC_WALK: begin
				walk_col <= walk_col + 9'h001;
				if (walk_col == `VDC_COL_LAST) begin
					state <= VDC_IDLE;
				end
			end
			default: state <= VDC_IDLE;
			endcase
		end
	end

	// Split walks cover only the half that the serial side is not using
	assign col_a = walk_split ? {~ptr[`VDC_HALF_BIT], walk_col[7:0]} : walk_col;

	// Random read/write or block write at column fall: function low at row fall
	assign cas_rw = state == VDC_ROW && cas_fall && !mode.refresh &&
	                !mode.transfer && !mode.func_row;
	assign ram_wr_now = !(wel_s && weu_s);

	//------------------------------------------------------------
	// Memory array writes
	//------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (state == VDC_WALK && mode.transfer && mode.masked) begin
			// Buffer to row under the latched mask
			mem[{row, col_a}] <= (mem[{row, col_a}] & ~wmask) |
			                     (serial_access_buffer[col_a] & wmask);
		end else if (state == VDC_WALK && !mode.transfer) begin
			mem[{row, walk_col}] <= (mem[{row, walk_col}] & ~wmask) |
			                        (color & wmask);
		end else if (cas_rw && ram_wr_now && !dsf_s) begin
			// Byte lanes follow the write enables; bit mask stays in force
			mem[{row, adr_s}] <= (mem[{row, adr_s}] &
			   ~(wmask & {{8{!weu_s}}, {8{!wel_s}}})) |
			   (dq_s & wmask & {{8{!weu_s}}, {8{!wel_s}}});
		end else if (cas_rw && dsf_s) begin
			// Block write: low column bits made here, data pins are column mask
			for (int b = 0; b < `VDC_BLK_COLS; b++) begin
				mem[{row, adr_s[`VDC_ADDR_W-1:`VDC_BLK_LSB], 3'(b)}] <=
				   (mem[{row, adr_s[`VDC_ADDR_W-1:`VDC_BLK_LSB], 3'(b)}] &
				   ~(wmask & {{8{dq_s[8+b]}}, {8{dq_s[b]}}})) |
				   (color & wmask & {{8{dq_s[8+b]}}, {8{dq_s[b]}}});
			end
		end
	end

	//------------------------------------------------------------
	// Color value, stop addresses and random read data
	//------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			color   <= `VDC_ZERO_WORD;
			stop_lo <= `VDC_HALF_LAST;
			stop_hi <= `VDC_HALF_LAST;
			o_dq    <= `VDC_ZERO_WORD;
		end else if (state == VDC_ROW && cas_fall) begin
			if (mode.refresh) begin
				// Refresh cycle also programs the stop address of a half
				if (adr_s[`VDC_HALF_BIT]) begin
					stop_hi <= adr_s[7:0];
				end else begin
					stop_lo <= adr_s[7:0];
				end
			end else if (!mode.transfer && mode.func_row && !mode.masked) begin
				if (ram_wr_now) begin
					color <= dq_s;
				end else begin
					o_dq <= color;
				end
			end else if (cas_rw && !dsf_s) begin
				o_dq <= mem[{row, adr_s}];
			end
		end
	end

	// Drive only with column strobe and output enable low, never on writes
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			o_dq_oe <= 1'b0;
		end else begin
			o_dq_oe <= (state == VDC_ROW) && !ras_s && !cas_s && !cas_fall &&
			           !mode.transfer && !mode.refresh && !mode.masked &&
			           !trg_s && wel_s && weu_s;
		end
	end

	//------------------------------------------------------------
	// Serial side: pointer, direction and split halves
	//------------------------------------------------------------
	// Non-split transfer starts and the serial clock both move the pointer
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			ptr        <= `VDC_ZERO_ADDR;
			tap        <= `VDC_ZERO_ADDR;
			split      <= 1'b0;
			walk_split <= 1'b0;
			out_mode   <= 1'b1;
		end else if (state == VDC_ROW && cas_fall && mode.transfer &&
		             !mode.refresh) begin
			out_mode   <= !mode.masked;
			split      <= mode.func_row;
			walk_split <= mode.func_row;
			if (mode.func_row) begin
				tap <= adr_s;        // taken up when the current half ends
			end else begin
				ptr <= adr_s;
			end
		end else if (sc_rise) begin
			if (split && ptr[7:0] == (ptr[`VDC_HALF_BIT] ? stop_hi : stop_lo)) begin
				ptr <= {~ptr[`VDC_HALF_BIT], tap[7:0]};
				tap <= `VDC_ZERO_ADDR;
			end else begin
				ptr <= ptr + 9'h001;
			end
		end
	end

	// One writer for the buffer: transfer sweeps win over serial capture
	always_ff @(posedge i_clk_sys) begin
		if (state == VDC_WALK && mode.transfer && !mode.masked) begin
			serial_access_buffer[col_a] <= mem[{row, col_a}];
		end else if (sc_rise && !out_mode && !se_s) begin
			serial_access_buffer[ptr] <= sdi_s;
		end
	end

	// In output mode the word follows each serial clock and the enables follow serial enable
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			o_serial_data_pins        <= `VDC_ZERO_WORD;
			o_serial_data_oe          <= 1'b0;
			o_split_half_indicator    <= 1'b0;
			o_split_half_indicator_oe <= 1'b0;
			o_mode                    <= '0;
		end else begin
			if (sc_rise && out_mode) begin
				o_serial_data_pins <= serial_access_buffer[ptr];
			end
			o_serial_data_oe          <= out_mode && !se_s;
			o_split_half_indicator    <= ptr[`VDC_HALF_BIT];
			o_split_half_indicator_oe <= !se_s;
			o_mode                    <= mode;
		end
	end

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);

	chk_standby_idle: assert property (ras_s && state == VDC_ROW |=>
		state == VDC_IDLE) else $error("row cycle kept while strobe high");
	chk_row_latch: assert property (state == VDC_IDLE && ras_fall |=>
		row == $past(adr_s)) else $error("row address not latched");
	chk_mode_decode: assert property (state == VDC_IDLE && ras_fall |=>
		mode.transfer == !$past(trg_s) && mode.func_row == $past(dsf_s))
		else $error("mode not decoded at row strobe fall");
	chk_mask_load: assert property (state == VDC_IDLE && ras_fall &&
		!wel_s |=> wmask == $past(dq_s)) else $error("mask not latched");
	chk_dq_gate: assert property (o_dq_oe |-> $past(!cas_s))
		else $error("data driven with column strobe high");
	chk_half_float: assert property (se_s |=> !o_split_half_indicator_oe)
		else $error("half indicator driven with enable high");
	chk_ptr_step: assert property (sc_rise && !split &&
		!(state == VDC_ROW && cas_fall) |=> ptr == $past(ptr) + 9'h001)
		else $error("pointer did not advance");
	chk_dir_follow: assert property (state == VDC_ROW && cas_fall &&
		mode.transfer && !mode.refresh |=> out_mode == !$past(mode.masked))
		else $error("serial direction not updated");
	chk_walk_len: assert property (state == VDC_IDLE && $past(state) ==
		VDC_WALK |-> $past(walk_col) == `VDC_COL_LAST)
		else $error("walk ended early");
	chk_half_show: assert property (##1 $past(ptr[`VDC_HALF_BIT]) ==
		o_split_half_indicator || $past(!i_rstn))
		else $error("half indicator off");
endmodule

//--- testbench/vdc_gfx_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Controller model: strobes, address, serial clock
// ----------------------------------------
module vdc_gfx_model (
	input  wire logic        i_clk_sys,
	output logic             o_ras_n,
	output logic             o_cas_n,
	output logic             o_trg_n,
	output logic             o_wel_n,
	output logic             o_weu_n,
	output logic             o_dsf,
	output logic [8:0]       o_addr,
	output logic [15:0]      o_dq,
	output logic             o_sc,
	output logic             o_se_n,
	output logic [15:0]      o_sdq
);
	// Strobes idle high, serial clock stands low
	initial begin
		{o_ras_n, o_cas_n, o_trg_n, o_wel_n, o_weu_n} = 5'h1f;
		{o_dsf, o_sc, o_se_n, o_addr, o_dq, o_sdq} = '0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge i_clk_sys);
	endtask

	// Mode pins and row go out one clock before the row strobe falls
	task automatic ras_fall(input logic transfer_output_enable_n, we, function_select_in,
			input logic [8:0] row, input logic [15:0] mask);
		o_trg_n <= transfer_output_enable_n;
		{o_wel_n, o_weu_n} <= {we, we};
		o_dsf <= function_select_in;
		o_addr <= row;
		o_dq <= mask;
		tick(1);
		o_ras_n <= 1'b0;
		tick(6);
	endtask

	// Column follows the row on the same pins
	task automatic cas_fall(input logic transfer_output_enable_n, we, function_select_in,
			input logic [8:0] col, input logic [15:0] data);
		o_trg_n <= transfer_output_enable_n;
		{o_wel_n, o_weu_n} <= {we, we};
		o_dsf <= function_select_in;
		o_addr <= col;
		o_dq <= data;
		tick(1);
		o_cas_n <= 1'b0;
		tick(8);
	endtask

	// Released lines show the inverse so stale values never pass
	task automatic ras_end();
		o_cas_n <= 1'b1;
		o_ras_n <= 1'b1;
		{o_wel_n, o_weu_n, o_trg_n} <= 3'h7;
		o_addr <= ~o_addr;
		o_dq <= ~o_dq;
		tick(6);
	endtask

	// One 160 ns serial clock period, then the clock stands low
	task automatic sc_pulse();
		o_sc <= 1'b1;
		tick(16);
		o_sc <= 1'b0;
		tick(16);
	endtask

	task automatic set_se(input logic v);
		o_se_n <= v;
		tick(6);
	endtask

	// Serial input word goes out a clock before the serial clock rises
	task automatic set_sdq(input logic [15:0] d);
		o_sdq <= d;
		tick(1);
	endtask
endmodule

//--- testbench/test_dual_port_video_dram_control.sv
`timescale 1ns/1ps
module test_dual_port_video_dram_control;
	import vdc_pkg::*;
	logic        i_clk_sys;
	logic        i_rstn;
	logic        ras_n, cas_n, trg_n, wel_n, weu_n, function_select_in, sc, se_n;
	logic [8:0]  addr;
	logic [15:0] dq, o_dq, sdq, o_sdq;
	logic        o_dq_oe, o_sdq_oe, o_half, o_half_oe;
	vdc_mode_s   o_mode;
	int          n_errors, comparisons;

	// ----------------------------------------
	// Clock, design and far side
	// ----------------------------------------
	always #2.5 i_clk_sys = ~i_clk_sys;

	vdc_dram_control vdc_dram_control_inst (
		.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
		.i_ras_n(ras_n), .i_cas_n(cas_n),
		.i_transfer_output_enable_n(trg_n),
		.i_write_enable_low_byte_n(wel_n),
		.i_write_enable_high_byte_n(weu_n),
		.i_function_select_in(function_select_in), .i_mux_address_pins(addr),
		.i_dq(dq), .o_dq(o_dq), .o_dq_oe(o_dq_oe),
		.i_serial_clock(sc), .i_serial_enable_n(se_n),
		.i_serial_data_pins(sdq), .o_serial_data_pins(o_sdq),
		.o_serial_data_oe(o_sdq_oe), .o_split_half_indicator(o_half),
		.o_split_half_indicator_oe(o_half_oe), .o_mode(o_mode));

	vdc_gfx_model vdc_gfx_model_inst (
		.i_clk_sys(i_clk_sys), .o_ras_n(ras_n), .o_cas_n(cas_n),
		.o_trg_n(trg_n), .o_wel_n(wel_n), .o_weu_n(weu_n),
		.o_dsf(function_select_in), .o_addr(addr), .o_dq(dq), .o_sc(sc),
		.o_se_n(se_n), .o_sdq(sdq));

	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic check(input logic [15:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("errors=%0d comparisons=%0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Early write; masked writes carry the mask at the row fall
	task automatic wr(input logic [8:0] row, col,
			input logic [15:0] mask, d, input logic masked);
		vdc_gfx_model_inst.ras_fall(1'b1, ~masked, 1'b0, row, mask);
		vdc_gfx_model_inst.cas_fall(1'b1, 1'b0, 1'b0, col, d);
		vdc_gfx_model_inst.ras_end();
	endtask

	// Read with output enable low; the wait is bounded
	task automatic rd(input logic [8:0] row, col, input logic [15:0] exp);
		int k;
		vdc_gfx_model_inst.ras_fall(1'b1, 1'b1, 1'b0, row, 16'h0000);
		check({12'h000, o_mode}, 16'h0000);
		vdc_gfx_model_inst.cas_fall(1'b0, 1'b1, 1'b0, col, 16'h0000);
		k = 0;
		while (o_dq_oe !== 1'b1 && k < 20) begin
			vdc_gfx_model_inst.tick(1);
			k++;
		end
		if (k == 20) begin
			n_errors++;
			conclude();
		end
		check(o_dq, exp);
		vdc_gfx_model_inst.ras_end();
		check(o_dq_oe, 1'b0);
	endtask

	task automatic t_random_rw();
		wr(9'h001, 9'h0ff, 16'h0000, 16'h1234, 1'b0);
		wr(9'h001, 9'h100, 16'h0000, 16'ha5c3, 1'b0);
		wr(9'h001, 9'h101, 16'h0000, 16'h0f0f, 1'b0);
		rd(9'h001, 9'h0ff, 16'h1234);
		rd(9'h001, 9'h101, 16'h0f0f);
	endtask

	// Low mask bits keep the old contents
	task automatic t_masked();
		wr(9'h001, 9'h0ff, 16'h00ff, 16'habcd, 1'b1);
		rd(9'h001, 9'h0ff, 16'h12cd);
	endtask

	// Row to buffer from tap 0ff; pointer crosses into the upper half
	task automatic t_read_transfer();
		vdc_gfx_model_inst.ras_fall(1'b0, 1'b1, 1'b0, 9'h001, 16'hffff);
		check({12'h000, o_mode}, 16'h0004);
		vdc_gfx_model_inst.cas_fall(1'b1, 1'b1, 1'b0, 9'h0ff, 16'h0000);
		vdc_gfx_model_inst.ras_end();
		vdc_gfx_model_inst.tick(520);
		check(o_sdq_oe, 1'b1);
		check(o_half, 1'b0);
		vdc_gfx_model_inst.set_se(1'b1);
		check(o_sdq_oe, 1'b0);
		check(o_half_oe, 1'b0);
		vdc_gfx_model_inst.sc_pulse();
		vdc_gfx_model_inst.set_se(1'b0);
		vdc_gfx_model_inst.sc_pulse();
		check(o_sdq, 16'ha5c3);
		check(o_half, 1'b1);
		check(o_half_oe, 1'b1);
		vdc_gfx_model_inst.sc_pulse();
		check(o_sdq, 16'h0f0f);
	endtask

	// Buffer to row 2, then the serial port turns to input
	task automatic t_write_transfer();
		vdc_gfx_model_inst.ras_fall(1'b0, 1'b0, 1'b0, 9'h002, 16'hffff);
		vdc_gfx_model_inst.cas_fall(1'b1, 1'b1, 1'b0, 9'h0ff, 16'h0000);
		vdc_gfx_model_inst.ras_end();
		vdc_gfx_model_inst.tick(520);
		check(o_sdq_oe, 1'b0);
		rd(9'h002, 9'h100, 16'ha5c3);
	endtask

	// Input mode from tap 0ff: enable low captures, enable high only steps
	task automatic t_serial_write();
		vdc_gfx_model_inst.set_sdq(16'h3c96);
		vdc_gfx_model_inst.sc_pulse();
		vdc_gfx_model_inst.set_se(1'b1);
		vdc_gfx_model_inst.set_sdq(16'h5a5a);
		vdc_gfx_model_inst.sc_pulse();
		vdc_gfx_model_inst.set_se(1'b0);
		check(o_half, 1'b1);
		vdc_gfx_model_inst.ras_fall(1'b0, 1'b0, 1'b0, 9'h003, 16'hffff);
		vdc_gfx_model_inst.cas_fall(1'b1, 1'b1, 1'b0, 9'h000, 16'h0000);
		vdc_gfx_model_inst.ras_end();
		vdc_gfx_model_inst.tick(520);
		rd(9'h003, 9'h0ff, 16'h3c96);
		rd(9'h003, 9'h100, 16'ha5c3);
	endtask

	// Color load and read, column-masked block write, masked flash write
	task automatic t_color_fill();
		vdc_gfx_model_inst.ras_fall(1'b1, 1'b1, 1'b1, 9'h004, 16'h0000);
		check({12'h000, o_mode}, 16'h0001);
		vdc_gfx_model_inst.cas_fall(1'b1, 1'b0, 1'b1, 9'h000, 16'h6e71);
		vdc_gfx_model_inst.ras_end();
		vdc_gfx_model_inst.ras_fall(1'b1, 1'b1, 1'b1, 9'h004, 16'h0000);
		vdc_gfx_model_inst.cas_fall(1'b0, 1'b1, 1'b1, 9'h000, 16'h0000);
		check(o_dq_oe, 1'b1);
		check(o_dq, 16'h6e71);
		vdc_gfx_model_inst.ras_end();
		wr(9'h004, 9'h109, 16'h0000, 16'h1111, 1'b0);
		vdc_gfx_model_inst.ras_fall(1'b1, 1'b1, 1'b0, 9'h004, 16'h0000);
		vdc_gfx_model_inst.cas_fall(1'b1, 1'b0, 1'b1, 9'h10d, 16'h0301);
		vdc_gfx_model_inst.ras_end();
		rd(9'h004, 9'h108, 16'h6e71);
		rd(9'h004, 9'h109, 16'h6e11);
		wr(9'h005, 9'h020, 16'h0000, 16'h4321, 1'b0);
		vdc_gfx_model_inst.ras_fall(1'b1, 1'b0, 1'b1, 9'h005, 16'hff00);
		check({12'h000, o_mode}, 16'h0003);
		vdc_gfx_model_inst.cas_fall(1'b1, 1'b1, 1'b0, 9'h000, 16'h0000);
		vdc_gfx_model_inst.ras_end();
		vdc_gfx_model_inst.tick(520);
		rd(9'h005, 9'h020, 16'h6e21);
	endtask

	initial begin
		i_clk_sys = 1'b0;
		i_rstn = 1'b0;
		n_errors = 0;
		comparisons = 0;
		repeat (10) @(posedge i_clk_sys);
		i_rstn <= 1'b1;
		vdc_gfx_model_inst.tick(3);
		t_random_rw();
		t_masked();
		t_read_transfer();
		t_write_transfer();
		t_serial_write();
		t_color_fill();
		conclude();
	end
endmodule
